// ===== rtl/lfsp_pkg.sv
// shared constants, types and helpers of the frame service port
package lfsp_pkg;

   localparam int ADDR_W    = 16;
   localparam int DATA_W    = 32;
   localparam int PRIO_W    = 3;
   localparam int TAG_W     = 4;

   // priority range, 0 lowest and 7 highest
   localparam logic [PRIO_W-1:0] PRIO_LOWEST  = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_HIGHEST = 3'h7;

   // the top address bit marks a group address
   localparam int ADDR_GROUP_BIT = ADDR_W - 1;
   localparam logic [ADDR_W-1:0] ADDR_ALL_STATIONS = 16'hFFFF;

   // response wait per attempt and the number of retries after the first send
   localparam int CLK_HZ          = 20_000_000;
   localparam int RESP_TIMEOUT_US = 100;
   localparam int RESP_TIMEOUT_CYC = (RESP_TIMEOUT_US * (CLK_HZ / 1_000_000) > 0) ?
                                     RESP_TIMEOUT_US * (CLK_HZ / 1_000_000) : 1;
   localparam int TIMER_W         = 12;
   localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(RESP_TIMEOUT_CYC - 1);
   localparam logic [1:0] MAX_RETRIES = 2'h3;

   // reset values
   localparam logic [TAG_W-1:0]   TAG_RESET   = 4'h0;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 12'h000;
   localparam logic [1:0]         RETRY_RESET = 2'h0;

   // delivery-confirmation mode; code 2'h2 is illegal
   typedef enum logic [1:0] {
      LFSP_NO_RESP   = 2'h0,
      LFSP_WANT_RESP = 2'h1,
      LFSP_IS_RESP   = 2'h3
   } lfsp_mode_t;

   typedef enum logic {
      LFSP_SUCCESS = 1'b0,
      LFSP_FAILURE = 1'b1
   } lfsp_status_t;

   function automatic logic lfsp_is_group(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_GROUP_BIT];
   endfunction

   function automatic logic lfsp_addr_match(input logic [ADDR_W-1:0] dest,
                                            input logic [ADDR_W-1:0] station,
                                            input logic [ADDR_W-1:0] group);
      return (dest == station) ||
             (lfsp_is_group(dest) && ((dest == group) || (dest == ADDR_ALL_STATIONS)));
   endfunction

endpackage

// ===== rtl/lfsp_if.sv
// service port between the medium access end and the link control end
interface lfsp_if;
   import lfsp_pkg::*;

   // send request, link control to medium access
   logic                req_valid;
   logic                req_ready;
   logic [ADDR_W-1:0]   req_dest;
   logic [ADDR_W-1:0]   req_src;
   logic [DATA_W-1:0]   req_payload;
   logic [PRIO_W-1:0]   req_prio;
   lfsp_mode_t          req_mode;

   // receive indication, medium access to link control
   logic                ind_valid;
   logic                ind_ready;
   logic [ADDR_W-1:0]   ind_dest;
   logic [ADDR_W-1:0]   ind_src;
   logic [DATA_W-1:0]   ind_payload;
   logic [PRIO_W-1:0]   ind_prio;
   lfsp_mode_t          ind_mode;
   logic                ind_assoc;
   logic [TAG_W-1:0]    ind_tag;

   // send confirmation, medium access to link control
   logic                cnf_valid;
   logic                cnf_ready;
   logic [ADDR_W-1:0]   cnf_dest;
   logic [ADDR_W-1:0]   cnf_src;
   lfsp_status_t        cnf_status;
   logic [PRIO_W-1:0]   cnf_prio;
   lfsp_mode_t          cnf_mode;
   logic [TAG_W-1:0]    cnf_tag;

   modport mac (
      input  req_valid, req_dest, req_src, req_payload, req_prio, req_mode,
      output req_ready,
      output ind_valid, ind_dest, ind_src, ind_payload, ind_prio, ind_mode, ind_assoc, ind_tag,
      input  ind_ready,
      output cnf_valid, cnf_dest, cnf_src, cnf_status, cnf_prio, cnf_mode, cnf_tag,
      input  cnf_ready
   );

   modport llc (
      output req_valid, req_dest, req_src, req_payload, req_prio, req_mode,
      input  req_ready,
      input  ind_valid, ind_dest, ind_src, ind_payload, ind_prio, ind_mode, ind_assoc, ind_tag,
      output ind_ready,
      input  cnf_valid, cnf_dest, cnf_src, cnf_status, cnf_prio, cnf_mode, cnf_tag,
      output cnf_ready
   );

endinterface

// ===== rtl/lfsp_llc_end.sv
// link control end: issues send requests, takes indications and confirmations
module lfsp_llc_end (
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   lfsp_if.llc                           port,
   input  wire logic                     cmd_valid,
   output      logic                     cmd_ready,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] cmd_dest,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] cmd_src,
   input  wire logic [lfsp_pkg::DATA_W-1:0] cmd_payload,
   input  wire logic [lfsp_pkg::PRIO_W-1:0] cmd_prio,
   input  wire logic [1:0]               cmd_mode,
   output      logic                     cmd_refused,
   output      logic                     reply_due,
   output      logic                     rcv_valid,
   output      logic [lfsp_pkg::ADDR_W-1:0] rcv_dest,
   output      logic [lfsp_pkg::ADDR_W-1:0] rcv_src,
   output      logic [lfsp_pkg::DATA_W-1:0] rcv_payload,
   output      logic [lfsp_pkg::PRIO_W-1:0] rcv_prio,
   output      logic [1:0]               rcv_mode,
   output      logic                     rcv_assoc,
   output      logic [lfsp_pkg::TAG_W-1:0]  rcv_tag,
   output      logic                     done_valid,
   output      logic [lfsp_pkg::ADDR_W-1:0] done_dest,
   output      logic [lfsp_pkg::ADDR_W-1:0] done_src,
   output      logic                     done_status,
   output      logic [lfsp_pkg::PRIO_W-1:0] done_prio,
   output      logic [1:0]               done_mode,
   output      logic [lfsp_pkg::TAG_W-1:0]  done_tag
);
   import lfsp_pkg::*;

   typedef enum logic {
      LL_IDLE  = 1'b0,
      LL_ISSUE = 1'b1
   } lfsp_ll_state_t;

   lfsp_ll_state_t      state, next_state;
   logic [ADDR_W-1:0]   dest, next_dest;
   logic [ADDR_W-1:0]   src, next_src;
   logic [DATA_W-1:0]   payload, next_payload;
   logic [PRIO_W-1:0]   prio, next_prio;
   lfsp_mode_t          mode, next_mode;
   logic                owed, next_owed;
   logic                refused, next_refused;
   logic                legal;

   ////////////////////////////////////////////////////////////////////////////
   // handshakes; both answer paths always sink, so nothing backs up
   assign cmd_ready      = (state == LL_IDLE);
   assign port.req_valid = (state == LL_ISSUE);
   assign port.ind_ready = 1'b1;
   assign port.cnf_ready = 1'b1;
   assign port.req_dest    = dest;
   assign port.req_src     = src;
   assign port.req_payload = payload;
   assign port.req_prio    = prio;
   assign port.req_mode    = mode;
   assign cmd_refused = refused;
   assign reply_due   = owed;

   // screen a command: illegal code, unearned response, group asking for response
   always_comb begin
      legal = 1'b1;
      if (!(cmd_mode inside {LFSP_NO_RESP, LFSP_WANT_RESP, LFSP_IS_RESP})) begin
         legal = 1'b0;
      end
      if ((cmd_mode == LFSP_IS_RESP) && !owed) begin
         legal = 1'b0;
      end
      if ((cmd_mode == LFSP_WANT_RESP) && lfsp_is_group(cmd_dest)) begin
         legal = 1'b0;
      end
      if (owed && (cmd_mode != LFSP_IS_RESP)) begin
         legal = 1'b0;
      end
   end

   // request state; a fresh indication decides what is owed, winning over a send
   always_comb begin
      next_state   = state;
      next_dest    = dest;
      next_src     = src;
      next_payload = payload;
      next_prio    = prio;
      next_mode    = mode;
      next_owed    = owed;
      next_refused = 1'b0;
      unique case (state)
         LL_IDLE: begin
            if (cmd_valid && legal) begin
               next_dest    = cmd_dest;
               next_src     = cmd_src;
               next_payload = cmd_payload;
               next_prio    = cmd_prio;
               next_mode    = lfsp_mode_t'(cmd_mode);
               next_state   = LL_ISSUE;
            end else if (cmd_valid) begin
               next_refused = 1'b1;
            end
         end
         LL_ISSUE: begin
            if (port.req_ready) begin
               next_state = LL_IDLE;
               if (mode == LFSP_IS_RESP) begin
                  next_owed = 1'b0;
               end
            end
         end
      endcase
      if (port.ind_valid) begin
         next_owed = (port.ind_mode == LFSP_WANT_RESP);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state   <= LL_IDLE;
         dest    <= '0;
         src     <= '0;
         payload <= '0;
         prio    <= PRIO_LOWEST;
         mode    <= LFSP_NO_RESP;
         owed    <= 1'b0;
         refused <= 1'b0;
      end else begin
         state   <= next_state;
         dest    <= next_dest;
         src     <= next_src;
         payload <= next_payload;
         prio    <= next_prio;
         mode    <= next_mode;
         owed    <= next_owed;
         refused <= next_refused;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // received frames and confirmations shown to the user for one cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rcv_valid   <= 1'b0;
         rcv_dest    <= '0;
         rcv_src     <= '0;
         rcv_payload <= '0;
         rcv_prio    <= PRIO_LOWEST;
         rcv_mode    <= LFSP_NO_RESP;
         rcv_assoc   <= 1'b0;
         rcv_tag     <= TAG_RESET;
         done_valid  <= 1'b0;
         done_dest   <= '0;
         done_src    <= '0;
         done_status <= LFSP_SUCCESS;
         done_prio   <= PRIO_LOWEST;
         done_mode   <= LFSP_NO_RESP;
         done_tag    <= TAG_RESET;
      end else begin
         rcv_valid  <= port.ind_valid;
         done_valid <= port.cnf_valid;
         if (port.ind_valid) begin
            rcv_dest    <= port.ind_dest;
            rcv_src     <= port.ind_src;
            rcv_payload <= port.ind_payload;
            rcv_prio    <= port.ind_prio;
            rcv_mode    <= port.ind_mode;
            rcv_assoc   <= port.ind_assoc;
            rcv_tag     <= port.ind_tag;
         end
         if (port.cnf_valid) begin
            done_dest   <= port.cnf_dest;
            done_src    <= port.cnf_src;
            done_status <= port.cnf_status;
            done_prio   <= port.cnf_prio;
            done_mode   <= port.cnf_mode;
            done_tag    <= port.cnf_tag;
         end
      end
   end

endmodule

// ===== rtl/lfsp_mac_end.sv
// medium access end: sends frames, filters received frames, confirms requests

// What this block does
// - requests carry addresses, payload and quality
// - quality holds priority 0..7 and mode
// - accepted request is built and transmitted
// - indicate only clean frames addressed here
// - indication shows addresses, payload and quality
// - next response indication links to waiting request
// - response send only after response-wanted indication
// - no group destination when response wanted
// - answer response-wanted indication at once
// - delivered payload equals the sent payload
// - response indication may name earlier request
// - confirm success, or failure on fault/timeout
// - confirmation returns addresses, status, quality
module lfsp_mac_end (
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   lfsp_if.mac                           port,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] station_addr,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] group_addr,
   input  wire logic                     local_fault,
   output      logic                     tx_valid,
   input  wire logic                     tx_ready,
   output      logic [lfsp_pkg::ADDR_W-1:0] tx_dest,
   output      logic [lfsp_pkg::ADDR_W-1:0] tx_src,
   output      logic [lfsp_pkg::DATA_W-1:0] tx_payload,
   output      logic [lfsp_pkg::PRIO_W-1:0] tx_prio,
   output      logic [1:0]               tx_mode,
   input  wire logic                     rx_valid,
   output      logic                     rx_ready,
   input  wire logic                     rx_is_data,
   input  wire logic                     rx_error,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] rx_dest,
   input  wire logic [lfsp_pkg::ADDR_W-1:0] rx_src,
   input  wire logic [lfsp_pkg::DATA_W-1:0] rx_payload,
   input  wire logic [lfsp_pkg::PRIO_W-1:0] rx_prio,
   input  wire logic [1:0]               rx_mode
);
   import lfsp_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_SEND    = 2'h1,
      ST_WAIT    = 2'h3,
      ST_CONFIRM = 2'h2
   } lfsp_state_t;

   lfsp_state_t         state, next_state;
   logic [ADDR_W-1:0]   cur_dest, next_cur_dest;
   logic [ADDR_W-1:0]   cur_src, next_cur_src;
   logic [DATA_W-1:0]   cur_payload, next_cur_payload;
   logic [PRIO_W-1:0]   cur_prio, next_cur_prio;
   lfsp_mode_t          cur_mode, next_cur_mode;
   lfsp_status_t        status, next_status;
   logic [TAG_W-1:0]    tag, next_tag;
   logic [1:0]          retry, next_retry;
   logic [TIMER_W-1:0]  timer, next_timer;
   logic                ind_valid, next_ind_valid;
   logic [ADDR_W-1:0]   ind_dest, next_ind_dest;
   logic [ADDR_W-1:0]   ind_src, next_ind_src;
   logic [DATA_W-1:0]   ind_payload, next_ind_payload;
   logic [PRIO_W-1:0]   ind_prio, next_ind_prio;
   lfsp_mode_t          ind_mode, next_ind_mode;
   logic                ind_assoc, next_ind_assoc;
   logic [TAG_W-1:0]    ind_tag, next_ind_tag;
   logic                accept_rx;
   logic                resp_hit;

   ////////////////////////////////////////////////////////////////////////////
   // handshakes and held data toward both parties
   assign port.req_ready = (state == ST_IDLE);
   assign tx_valid       = (state == ST_SEND);
   assign tx_dest        = cur_dest;
   assign tx_src         = cur_src;
   assign tx_payload     = cur_payload;
   assign tx_prio        = cur_prio;
   assign tx_mode        = cur_mode;
   assign port.cnf_valid  = (state == ST_CONFIRM);
   assign port.cnf_dest   = cur_dest;
   assign port.cnf_src    = cur_src;
   assign port.cnf_status = status;
   assign port.cnf_prio   = cur_prio;
   assign port.cnf_mode   = cur_mode;
   assign port.cnf_tag    = tag;

   // the medium is held off while an indication waits, so no frame is dropped
   assign rx_ready = !ind_valid;
   assign accept_rx = rx_valid && rx_ready && rx_is_data && !rx_error &&
                      lfsp_addr_match(rx_dest, station_addr, group_addr);
   assign resp_hit  = accept_rx && (state == ST_WAIT) && (rx_mode == LFSP_IS_RESP);

   assign port.ind_valid   = ind_valid;
   assign port.ind_dest    = ind_dest;
   assign port.ind_src     = ind_src;
   assign port.ind_payload = ind_payload;
   assign port.ind_prio    = ind_prio;
   assign port.ind_mode    = ind_mode;
   assign port.ind_assoc   = ind_assoc;
   assign port.ind_tag     = ind_tag;

   ////////////////////////////////////////////////////////////////////////////
   // indication holding register, loaded only when empty
   always_comb begin
      next_ind_valid   = ind_valid;
      next_ind_dest    = ind_dest;
      next_ind_src     = ind_src;
      next_ind_payload = ind_payload;
      next_ind_prio    = ind_prio;
      next_ind_mode    = ind_mode;
      next_ind_assoc   = ind_assoc;
      next_ind_tag     = ind_tag;
      if (accept_rx) begin
         next_ind_valid   = 1'b1;
         next_ind_dest    = rx_dest;
         next_ind_src     = rx_src;
         next_ind_payload = rx_payload;
         next_ind_prio    = rx_prio;
         next_ind_mode    = lfsp_mode_t'(rx_mode);
         next_ind_assoc   = resp_hit;
         next_ind_tag     = tag;
      end else if (ind_valid && port.ind_ready) begin
         next_ind_valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ind_valid   <= 1'b0;
         ind_dest    <= '0;
         ind_src     <= '0;
         ind_payload <= '0;
         ind_prio    <= PRIO_LOWEST;
         ind_mode    <= LFSP_NO_RESP;
         ind_assoc   <= 1'b0;
         ind_tag     <= TAG_RESET;
      end else begin
         ind_valid   <= next_ind_valid;
         ind_dest    <= next_ind_dest;
         ind_src     <= next_ind_src;
         ind_payload <= next_ind_payload;
         ind_prio    <= next_ind_prio;
         ind_mode    <= next_ind_mode;
         ind_assoc   <= next_ind_assoc;
         ind_tag     <= next_ind_tag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request sequencer; a response beats a fault or timeout in the same cycle
   always_comb begin
      next_state       = state;
      next_cur_dest    = cur_dest;
      next_cur_src     = cur_src;
      next_cur_payload = cur_payload;
      next_cur_prio    = cur_prio;
      next_cur_mode    = cur_mode;
      next_status      = status;
      next_tag         = tag;
      next_retry       = retry;
      next_timer       = timer;
      unique case (state)
         ST_IDLE: begin
            if (port.req_valid) begin
               next_cur_dest    = port.req_dest;
               next_cur_src     = port.req_src;
               next_cur_payload = port.req_payload;
               next_cur_prio    = port.req_prio;
               next_cur_mode    = port.req_mode;
               next_retry       = RETRY_RESET;
               next_state       = ST_SEND;
            end
         end
         ST_SEND: begin
            if (local_fault) begin
               next_status = LFSP_FAILURE;
               next_state  = ST_CONFIRM;
            end else if (tx_ready) begin
               next_timer = TIMER_RESET;
               if (cur_mode == LFSP_WANT_RESP) begin
                  next_state = ST_WAIT;
               end else begin
                  next_status = LFSP_SUCCESS;
                  next_state  = ST_CONFIRM;
               end
            end
         end
         ST_WAIT: begin
            if (resp_hit) begin
               next_status = LFSP_SUCCESS;
               next_state  = ST_CONFIRM;
            end else if (local_fault) begin
               next_status = LFSP_FAILURE;
               next_state  = ST_CONFIRM;
            end else if (timer == TIMER_LAST) begin
               if (retry == MAX_RETRIES) begin
                  next_status = LFSP_FAILURE;
                  next_state  = ST_CONFIRM;
               end else begin
                  next_retry = retry + 2'h1;
                  next_state = ST_SEND;
               end
            end else begin
               next_timer = timer + 12'h001;
            end
         end
         ST_CONFIRM: begin
            if (port.cnf_ready) begin
               next_tag   = tag + 4'h1;
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= ST_IDLE;
         cur_dest    <= '0;
         cur_src     <= '0;
         cur_payload <= '0;
         cur_prio    <= PRIO_LOWEST;
         cur_mode    <= LFSP_NO_RESP;
         status      <= LFSP_SUCCESS;
         tag         <= TAG_RESET;
         retry       <= RETRY_RESET;
         timer       <= TIMER_RESET;
      end else begin
         state       <= next_state;
         cur_dest    <= next_cur_dest;
         cur_src     <= next_cur_src;
         cur_payload <= next_cur_payload;
         cur_prio    <= next_cur_prio;
         cur_mode    <= next_cur_mode;
         status      <= next_status;
         tag         <= next_tag;
         retry       <= next_retry;
         timer       <= next_timer;
      end
   end

endmodule

// ===== dv/lfsp_port_asserts.sv
// concurrent checks on the service port joining the two ends
module lfsp_port_asserts (
   input wire logic                        sys_clk,
   input wire logic                        reset_n,
   input wire logic                        req_valid,
   input wire logic                        req_ready,
   input wire logic [lfsp_pkg::ADDR_W-1:0] req_dest,
   input wire lfsp_pkg::lfsp_mode_t        req_mode,
   input wire logic                        ind_valid,
   input wire lfsp_pkg::lfsp_mode_t        ind_mode,
   input wire logic                        ind_assoc,
   input wire logic [lfsp_pkg::TAG_W-1:0]  ind_tag,
   input wire logic                        cnf_valid,
   input wire logic [lfsp_pkg::ADDR_W-1:0] cnf_dest,
   input wire lfsp_pkg::lfsp_status_t      cnf_status,
   input wire logic [lfsp_pkg::TAG_W-1:0]  cnf_tag
);
   timeunit 1ns;
   timeprecision 1ns;
   import lfsp_pkg::*;

   logic [ADDR_W-1:0] sent_dest;
   logic              owed;

   ////////////////////////////////////////////////////////////
   // last taken destination and whether a reply to the newest indication is still owed
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sent_dest <= '0;
         owed      <= 1'b0;
      end else begin
         if (req_valid && req_ready)
            sent_dest <= req_dest;
         if (ind_valid)
            owed <= (ind_mode == LFSP_WANT_RESP);
         else if (req_valid && req_ready && req_mode == LFSP_IS_RESP)
            owed <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // a plain send being taken, and a clean confirmation
   sequence s_plain_take;
      req_valid && req_ready && req_mode == LFSP_NO_RESP;
   endsequence
   sequence s_good_cnf;
      cnf_valid && cnf_status == LFSP_SUCCESS;
   endsequence

   a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_dest))
      else $error("request changed before taken");
   a_mode_legal: assert property (req_valid |-> req_mode != 2'h2)
      else $error("illegal mode code sent");
   a_no_group_want: assert property (req_valid && req_mode == LFSP_WANT_RESP |-> !req_dest[ADDR_W-1])
      else $error("group destination with reply wanted");
   a_resp_owed: assert property (req_valid && req_mode == LFSP_IS_RESP |-> owed)
      else $error("response sent with no reply owed");
   a_plain_cnf: assert property (s_plain_take |-> ##[2:40] cnf_valid)
      else $error("plain send never confirmed");
   a_cnf_dest: assert property (cnf_valid |-> cnf_dest == sent_dest)
      else $error("confirmation names wrong destination");
   a_assoc_link: assert property (ind_valid && ind_assoc |-> s_good_cnf ##0 ind_tag == cnf_tag)
      else $error("linked response not confirmed");
   a_tag_step: assert property (cnf_valid |=> cnf_tag == $past(cnf_tag) + 4'h1)
      else $error("tag did not advance");
endmodule

// ===== dv/tb.sv
// bench joining both ends and driving the link control user side and the medium side
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lfsp_pkg::*;

   localparam logic [15:0] STN = 16'h0012;
   localparam logic [15:0] GRP = 16'h8034;
   localparam logic [15:0] FD [7] = '{STN, STN, STN, 16'h0099, 16'h8099, GRP, 16'hFFFF};
   localparam logic [1:0]  FB [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};

   logic        sys_clk, reset_n, local_fault, tx_valid, tx_ready, rx_valid, rx_ready, rx_is_data, rx_error;
   logic        cmd_valid, cmd_ready, cmd_refused, reply_due, rcv_valid, rcv_assoc, done_valid, done_status;
   logic [1:0]  cmd_mode, rx_mode, rcv_mode;
   logic [15:0] cmd_dest, rx_dest, rx_src, rcv_src, rcv_dest, done_dest;
   logic [2:0]  rcv_prio, done_prio;
   logic [31:0] cmd_payload, rx_payload, tx_payload, rcv_payload, sent_word;
   int          bad_count, num_checks, rcv_count, ref_count, n0;

   lfsp_if lfsp_if_i ();
   lfsp_mac_end lfsp_mac_end_i (.sys_clk, .reset_n, .port(lfsp_if_i.mac), .station_addr(STN), .group_addr(GRP),
      .local_fault, .tx_valid, .tx_ready, .tx_dest(), .tx_src(), .tx_payload, .tx_prio(), .tx_mode(), .rx_valid,
      .rx_ready, .rx_is_data, .rx_error, .rx_dest, .rx_src, .rx_payload, .rx_prio(3'h2), .rx_mode);
   lfsp_llc_end lfsp_llc_end_i (.sys_clk, .reset_n, .port(lfsp_if_i.llc), .cmd_valid, .cmd_ready, .cmd_dest,
      .cmd_src(STN), .cmd_payload, .cmd_prio(3'h5), .cmd_mode, .cmd_refused, .reply_due, .rcv_valid, .rcv_dest,
      .rcv_src, .rcv_payload, .rcv_prio, .rcv_mode, .rcv_assoc, .rcv_tag(), .done_valid, .done_dest,
      .done_src(), .done_status, .done_prio, .done_mode(), .done_tag());
   lfsp_port_asserts lfsp_port_asserts_i (.sys_clk, .reset_n, .req_valid(lfsp_if_i.req_valid),
      .req_ready(lfsp_if_i.req_ready), .req_dest(lfsp_if_i.req_dest), .req_mode(lfsp_if_i.req_mode),
      .ind_valid(lfsp_if_i.ind_valid), .ind_mode(lfsp_if_i.ind_mode), .ind_assoc(lfsp_if_i.ind_assoc),
      .ind_tag(lfsp_if_i.ind_tag), .cnf_valid(lfsp_if_i.cnf_valid), .cnf_dest(lfsp_if_i.cnf_dest),
      .cnf_status(lfsp_if_i.cnf_status), .cnf_tag(lfsp_if_i.cnf_tag));

   ////////////////////////////////////////////////////////////
   always #25 sys_clk = ~sys_clk;

   // pre-edge values: counts indications and refusals, keeps the word put on the medium
   always @(posedge sys_clk) begin
      rcv_count <= rcv_count + int'(rcv_valid);
      ref_count <= ref_count + int'(cmd_refused);
      if (tx_valid && tx_ready)
         sent_word <= tx_payload;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
         bad_count++;
      end
   endtask

   // command held until the edge where ready is seen high
   task automatic send(input logic [15:0] d, input logic [1:0] m, input logic [31:0] p);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_dest <= d;
      cmd_mode <= m;
      cmd_payload <= p;
      do @(negedge sys_clk); while (!cmd_ready);
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      cmd_payload <= ~p;
   endtask

   // bad[0] marks a detected error, bad[1] a non-data frame
   task automatic frame(input logic [15:0] d, input logic [1:0] m, input logic [1:0] bad);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_dest <= d;
      rx_mode <= m;
      rx_error <= bad[0];
      rx_is_data <= !bad[1];
      rx_src <= d ^ 16'h5A5A;
      rx_payload <= {d, ~d};
      do @(negedge sys_clk); while (!rx_ready);
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_payload <= ~rx_payload;
   endtask

   task automatic wait_done(input logic [15:0] d, input logic st, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (!done_valid && n < lim);
      chk(done_valid, 1'b1);
      chk(done_status, st);
      chk(done_dest, d);
      chk(done_prio, 3'h5);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // longest case is four unanswered attempts of 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      results();
   end

   initial begin
      {sys_clk, reset_n, local_fault, rx_valid, cmd_valid, rx_error, tx_ready, rx_is_data} = 8'h03;
      {cmd_dest, cmd_payload, cmd_mode, rx_dest, rx_src, rx_payload, rx_mode} = '0;
      {bad_count, num_checks, rcv_count, ref_count} = '0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      send(16'h0044, 2'h0, 32'hA5A50001);
      wait_done(16'h0044, LFSP_SUCCESS, 40);
      chk(sent_word, 32'hA5A50001);
      n0 = ref_count;
      send(16'h0044, 2'h2, 32'h0);
      send(GRP, 2'h1, 32'h0);
      send(16'h0044, 2'h3, 32'h0);
      repeat (3) @(posedge sys_clk);
      chk(ref_count - n0, 3);
      send(16'h0044, 2'h1, 32'h1);
      repeat (4) @(posedge sys_clk);
      n0 = rcv_count;
      frame(STN, 2'h3, 2'h0);
      wait_done(16'h0044, LFSP_SUCCESS, 40);
      chk({rcv_assoc, rcv_mode}, 3'h7);
      for (int i = 0; i < 7; i++)
         frame(FD[i], 2'h0, FB[i]);
      repeat (3) @(posedge sys_clk);
      chk(rcv_count - n0, 4);
      chk(rcv_dest, 16'hFFFF);
      chk(rcv_prio, 3'h2);
      chk(rcv_payload, 32'hFFFF0000);
      chk(rcv_src, 16'hA5A5);
      frame(STN, 2'h1, 2'h0);
      repeat (3) @(posedge sys_clk);
      chk(reply_due, 1'b1);
      n0 = ref_count;
      send(16'h0077, 2'h0, 32'h2);
      send(16'h0077, 2'h3, 32'h3);
      wait_done(16'h0077, LFSP_SUCCESS, 40);
      chk({ref_count - n0, reply_due}, 2);
      tx_ready <= 1'b0;
      send(16'h0044, 2'h0, 32'h4);
      repeat (5) @(posedge sys_clk);
      local_fault <= 1'b1;
      wait_done(16'h0044, LFSP_FAILURE, 40);
      @(posedge sys_clk);
      {local_fault, tx_ready} <= 2'h1;
      send(16'h0055, 2'h1, 32'h5);
      send(16'h0066, 2'h0, 32'h6);
      wait_done(16'h0055, LFSP_FAILURE, 9000);
      wait_done(16'h0066, LFSP_SUCCESS, 40);
      results();
   end
endmodule
